// ===== rtl/sstc_core.sv
// Sensor scan timing control: counters, dividers, oscillator calibration, DAC and timing sequencer.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module sstc_core (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    input  wire logic        i_aux_clk,
    input  wire logic        i_osc_clk,
    input  wire logic        i_proc_step,
    input  wire logic        i_count_up_bit,
    input  wire logic        i_count_down_bit,
    input  wire logic        i_high_branch_bit,
    input  wire logic        i_low_branch_bit,
    output logic      [1:0]  o_next_branch,
    output logic             o_osc_enable,
    output logic             o_osc_nominal_select,
    output logic      [3:0]  o_osc_trim,
    output logic             o_hf_from_osc,
    output logic             o_tsm_active,
    output logic      [2:0]  o_tsm_index,
    output logic      [15:0] o_tsm_entry,
    output logic             o_seq_end,
    output logic      [79:0] o_dac_levels
);

    // -------------------------------------------------------------------
    // State record
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                                    ctl_cnt;
        logic [15:0]                                    ctl_osc;
        logic [7:0]                                     cnt1;
        logic [7:0]                                     cnt2;
        logic [sstc_pkg::NUM_DAC-1:0][sstc_pkg::DAC_W-1:0] dac;
        logic [sstc_pkg::NUM_TSM-1:0][15:0]             tsm;
        logic [15:0]                                    rdata;
        logic [1:0]                                     branch;
        logic                                           aux_s1;
        logic                                           aux_s2;
        logic                                           aux_s3;
        logic                                           osc_s1;
        logic                                           osc_s2;
        logic                                           osc_s3;
        logic [2:0]                                     fast_div;
        logic [2:0]                                     aux_div;
        logic [9:0]                                     trig_cnt;
        sstc_pkg::sstc_seq_t                            seq;
        logic [2:0]                                     idx;
        logic [4:0]                                     rep;
        logic [15:0]                                    entry;
        logic                                           seq_end;
        sstc_pkg::sstc_cal_t                            cal;
        logic [1:0]                                     cal_win;
        logic [7:0]                                     cal_cnt;
        logic                                           cal_req;
    } sstc_state_t;

    sstc_state_t s_q;
    sstc_state_t s_d;

    logic        aux_edge;
    logic        osc_edge;
    logic [2:0]  fast_lim;
    logic [2:0]  aux_lim;
    logic        fast_tick;
    logic        aux_tick;
    logic        hf_tick;
    logic        osc_en;
    logic        repeat_mode;
    logic [2:0]  div_a;
    logic [2:0]  div_b;
    logic [9:0]  trig_n;
    logic        trig_tick;
    logic [15:0] cur;
    logic        cur_stop;
    logic        state_tick;
    logic        cal_req;
    logic        clr_read;
    logic        dac_hit;
    logic        tsm_hit;

    // -------------------------------------------------------------------
    // Clock edges and dividers
    // -------------------------------------------------------------------
    assign aux_edge    = s_q.aux_s2 & ~s_q.aux_s3;
    assign osc_edge    = s_q.osc_s2 & ~s_q.osc_s3;
    assign osc_en      = s_q.ctl_osc[sstc_pkg::OSC_EN_BIT];
    assign repeat_mode = s_q.ctl_osc[sstc_pkg::REPEAT_BIT];
    assign fast_lim    = 3'((4'h1 << s_q.ctl_cnt[sstc_pkg::FASTDIV_LSB +: 2]) - 4'h1);
    assign aux_lim     = 3'((4'h1 << s_q.ctl_cnt[sstc_pkg::AUXDIV_LSB +: 2]) - 4'h1);
    assign fast_tick   = (s_q.fast_div == fast_lim);
    assign aux_tick    = aux_edge && (s_q.aux_div == aux_lim);
    assign hf_tick     = osc_en ? osc_edge : fast_tick;
    assign div_a       = s_q.ctl_cnt[sstc_pkg::DIVA_LSB +: 3];
    assign div_b       = s_q.ctl_cnt[sstc_pkg::DIVB_LSB +: 3];
    assign trig_n      = 10'(2 * (2 * int'(div_a) + 1) * (2 * int'(div_b) + 1));
    assign trig_tick   = aux_tick && (s_q.trig_cnt >= 10'(trig_n - 10'h001));
    assign cur         = s_q.tsm[s_q.idx];
    assign cur_stop    = cur[sstc_pkg::STOP_BIT];
    assign state_tick  = cur[sstc_pkg::SLOW_BIT] ? aux_tick : hf_tick;
    assign cal_req     = osc_en & s_q.ctl_osc[sstc_pkg::CAL_BIT];
    assign clr_read    = i_rd && (i_addr == sstc_pkg::ADDR_SCAN_CNT) && s_q.ctl_cnt[sstc_pkg::CLR_RD_BIT];
    assign dac_hit     = (i_addr[7:3] == sstc_pkg::ADDR_DAC_BASE[7:3]);
    assign tsm_hit     = (i_addr[7:3] == sstc_pkg::ADDR_TSM_BASE[7:3]);

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        s_d.aux_s1 = i_aux_clk;
        s_d.aux_s2 = s_q.aux_s1;
        s_d.aux_s3 = s_q.aux_s2;
        s_d.osc_s1 = i_osc_clk;
        s_d.osc_s2 = s_q.osc_s1;
        s_d.osc_s3 = s_q.osc_s2;
        s_d.seq_end = 1'b0;
        s_d.rdata  = 16'h0000;

        s_d.fast_div = fast_tick ? 3'h0 : 3'(s_q.fast_div + 3'h1);
        if (aux_edge) begin
            s_d.aux_div = (s_q.aux_div == aux_lim) ? 3'h0 : 3'(s_q.aux_div + 3'h1);
        end
        if (aux_tick) begin
            s_d.trig_cnt = trig_tick ? 10'h000 : 10'(s_q.trig_cnt + 10'h001);
        end

        if (i_wr) begin
            if (i_addr == sstc_pkg::ADDR_CTL_CNT) begin
                s_d.ctl_cnt = i_wdata;
            end
            if (i_addr == sstc_pkg::ADDR_CTL_OSC) begin
                s_d.ctl_osc = (s_q.ctl_osc & ~sstc_pkg::CTL_OSC_WMASK) | (i_wdata & sstc_pkg::CTL_OSC_WMASK);
            end
            if (dac_hit) begin
                s_d.dac[i_addr[2:0]] = i_wdata[sstc_pkg::DAC_W-1:0];
            end
            if (tsm_hit) begin
                s_d.tsm[i_addr[2:0]] = i_wdata;
            end
        end

        if (i_rd) begin
            if (i_addr == sstc_pkg::ADDR_CTL_CNT) begin
                s_d.rdata = s_q.ctl_cnt;
            end else if (i_addr == sstc_pkg::ADDR_CTL_OSC) begin
                s_d.rdata = s_q.ctl_osc;
            end else if (i_addr == sstc_pkg::ADDR_SCAN_CNT) begin
                s_d.rdata = {s_q.cnt2, s_q.cnt1};
            end else if (dac_hit) begin
                s_d.rdata = {6'h00, s_q.dac[i_addr[2:0]]};
            end else if (tsm_hit) begin
                s_d.rdata = s_q.tsm[i_addr[2:0]];
            end
        end

        // A count event in the clearing cycle is applied on top of zero.
        if (clr_read) begin
            s_d.cnt1 = 8'h00;
            s_d.cnt2 = 8'h00;
        end
        if (i_proc_step) begin
            if (i_count_up_bit && s_q.ctl_cnt[sstc_pkg::UP_EN_BIT]) begin
                s_d.cnt1 = 8'(s_d.cnt1 + 8'h01);
            end
            if (i_count_down_bit && s_q.ctl_cnt[sstc_pkg::DN_EN_BIT]) begin
                s_d.cnt1 = 8'(s_d.cnt1 - 8'h01);
            end
            if (i_count_down_bit && s_q.ctl_cnt[sstc_pkg::CNT2_EN_BIT]) begin
                s_d.cnt2 = 8'(s_d.cnt2 - 8'h01);
            end
            s_d.branch[1] = i_high_branch_bit && s_q.ctl_cnt[sstc_pkg::HI_BR_BIT]
                            && s_q.ctl_cnt[sstc_pkg::LO_BR_BIT];
            s_d.branch[0] = i_low_branch_bit && s_q.ctl_cnt[sstc_pkg::LO_BR_BIT];
        end

        unique case (s_q.seq)
            sstc_pkg::SEQ_IDLE: begin
                if (repeat_mode || trig_tick) begin
                    s_d.seq = sstc_pkg::SEQ_RUN;
                    s_d.idx = 3'h0;
                    s_d.rep = 5'h00;
                end
            end
            sstc_pkg::SEQ_RUN: begin
                if (cur_stop) begin
                    if (hf_tick) begin
                        s_d.seq_end = 1'b1;
                        s_d.idx     = 3'h0;
                        s_d.rep     = 5'h00;
                        s_d.seq     = repeat_mode ? sstc_pkg::SEQ_RUN : sstc_pkg::SEQ_IDLE;
                    end
                end else if (state_tick) begin
                    if (s_q.rep == cur[sstc_pkg::REP_LSB +: 5]) begin
                        s_d.rep = 5'h00;
                        s_d.idx = 3'(s_q.idx + 3'h1);
                    end else begin
                        s_d.rep = 5'(s_q.rep + 5'h01);
                    end
                end
            end
        endcase

        s_d.cal_req = cal_req;
        unique case (s_q.cal)
            sstc_pkg::CAL_IDLE: begin
                if (cal_req && !s_q.cal_req) begin
                    s_d.cal = sstc_pkg::CAL_ARM;
                end
            end
            sstc_pkg::CAL_ARM: begin
                if (!cal_req) begin
                    s_d.cal = sstc_pkg::CAL_IDLE;
                end else if (aux_edge) begin
                    s_d.cal     = sstc_pkg::CAL_COUNT;
                    s_d.cal_cnt = 8'h00;
                    s_d.cal_win = 2'h0;
                end
            end
            sstc_pkg::CAL_COUNT: begin
                if (osc_edge && s_q.cal_cnt != 8'hFF) begin
                    s_d.cal_cnt = 8'(s_q.cal_cnt + 8'h01);
                end
                if (!cal_req) begin
                    s_d.cal = sstc_pkg::CAL_IDLE;
                end else if (aux_edge) begin
                    if (s_q.cal_win == (s_q.ctl_osc[sstc_pkg::NOM_BIT] ?
                                        sstc_pkg::CAL_WIN_SLOW : sstc_pkg::CAL_WIN_FAST)) begin
                        s_d.ctl_osc[sstc_pkg::CYC_CNT_LSB +: 8] = s_d.cal_cnt;
                        s_d.cal = sstc_pkg::CAL_IDLE;
                    end else begin
                        s_d.cal_win = 2'(s_q.cal_win + 2'h1);
                    end
                end
            end
            default: begin
                s_d.cal = sstc_pkg::CAL_IDLE;
            end
        endcase

        s_d.entry = s_d.tsm[s_d.idx];
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q         <= '0;
            s_q.ctl_cnt <= sstc_pkg::CTL_CNT_RST;
            s_q.ctl_osc <= sstc_pkg::CTL_OSC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign o_rdata              = s_q.rdata;
    assign o_next_branch        = s_q.branch;
    assign o_osc_enable         = osc_en;
    assign o_osc_nominal_select = s_q.ctl_osc[sstc_pkg::NOM_BIT];
    assign o_osc_trim           = s_q.ctl_osc[sstc_pkg::TRIM_LSB +: 4];
    assign o_hf_from_osc        = osc_en;
    assign o_tsm_active         = (s_q.seq == sstc_pkg::SEQ_RUN);
    assign o_tsm_index          = s_q.idx;
    assign o_tsm_entry          = s_q.entry;
    assign o_seq_end            = s_q.seq_end;

    genvar g;
    generate
        for (g = 0; g < sstc_pkg::NUM_DAC; g++) begin : g_dac
            assign o_dac_levels[g*sstc_pkg::DAC_W +: sstc_pkg::DAC_W] = s_q.dac[g];
        end
    endgenerate

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_stop_done;
        s_q.seq == sstc_pkg::SEQ_RUN && cur_stop && hf_tick;
    endsequence

    sequence s_state_expire;
        s_q.seq == sstc_pkg::SEQ_RUN && !cur_stop && state_tick && s_q.rep == cur[sstc_pkg::REP_LSB +: 5];
    endsequence

    a_clear_on_read: assert property (clr_read && !i_proc_step |=>
        o_rdata == {$past(s_q.cnt2), $past(s_q.cnt1)} && s_q.cnt1 == 8'h00 && s_q.cnt2 == 8'h00)
        else $error("Clear-on-read returned wrong value or did not clear.");
    a_cnt2_disabled: assert property (!s_q.ctl_cnt[sstc_pkg::CNT2_EN_BIT] && !clr_read |=>
        s_q.cnt2 == $past(s_q.cnt2))
        else $error("Second counter moved while disabled.");
    a_down_ignored: assert property (i_proc_step && !i_count_up_bit && !clr_read
        && !s_q.ctl_cnt[sstc_pkg::DN_EN_BIT] |=> s_q.cnt1 == $past(s_q.cnt1))
        else $error("First counter decremented while disabled.");
    a_up_counts: assert property (i_proc_step && i_count_up_bit && !i_count_down_bit && !clr_read
        |=> s_q.cnt1 == 8'($past(s_q.cnt1) + {7'h00, $past(s_q.ctl_cnt[sstc_pkg::UP_EN_BIT])}))
        else $error("First counter increment wrong.");
    a_branch_gate: assert property (i_proc_step && !s_q.ctl_cnt[sstc_pkg::LO_BR_BIT]
        |=> o_next_branch == 2'h0)
        else $error("Branch bit passed while low branch disabled.");
    a_dac_upper: assert property (i_rd && dac_hit |=> o_rdata[15:10] == 6'h00)
        else $error("DAC upper bits not zero.");
    a_trig_start: assert property (s_q.seq == sstc_pkg::SEQ_IDLE && trig_tick
        |=> o_tsm_active && o_tsm_index == 3'h0)
        else $error("Trigger did not start sequence at first state.");
    a_stop_end: assert property (s_stop_done |=> o_seq_end && o_tsm_index == 3'h0
        && o_tsm_active == $past(repeat_mode))
        else $error("Stop state did not end sequence correctly.");
    a_state_advance: assert property (s_state_expire |=> o_tsm_index == 3'($past(s_q.idx) + 3'h1))
        else $error("Sequencer did not advance after duration.");
    a_state_hold: assert property (s_q.seq == sstc_pkg::SEQ_RUN && !cur_stop
        && s_q.rep != cur[sstc_pkg::REP_LSB +: 5] |=> o_tsm_index == $past(s_q.idx))
        else $error("Sequencer left state early.");
    a_cal_gated: assert property (!osc_en && s_q.cal == sstc_pkg::CAL_IDLE
        |=> s_q.cal == sstc_pkg::CAL_IDLE)
        else $error("Calibration started with oscillator disabled.");
    a_down_counts: assert property (i_proc_step && !i_count_up_bit && i_count_down_bit
        && !clr_read && s_q.ctl_cnt[sstc_pkg::DN_EN_BIT] |=> s_q.cnt1 == 8'($past(s_q.cnt1) - 8'h01))
        else $error("First counter did not decrement.");
    a_cnt2_down: assert property (i_proc_step && i_count_down_bit && !clr_read
        && s_q.ctl_cnt[sstc_pkg::CNT2_EN_BIT] |=> s_q.cnt2 == 8'($past(s_q.cnt2) - 8'h01))
        else $error("Second counter did not decrement.");
    a_branch_pass: assert property (i_proc_step && s_q.ctl_cnt[sstc_pkg::HI_BR_BIT]
        && s_q.ctl_cnt[sstc_pkg::LO_BR_BIT] |=> o_next_branch == {$past(i_high_branch_bit), $past(i_low_branch_bit)})
        else $error("Enabled branch bits were not passed.");
    a_stop_hold: assert property (s_q.seq == sstc_pkg::SEQ_RUN && cur_stop && !hf_tick
        |=> o_tsm_active && !o_seq_end && o_tsm_index == $past(s_q.idx))
        else $error("Stop state ended before a fast clock period.");
    a_repeat_start: assert property (s_q.seq == sstc_pkg::SEQ_IDLE && repeat_mode
        |=> o_tsm_active && o_tsm_index == 3'h0)
        else $error("Repeat mode did not start a sequence at once.");
    a_idle_wait: assert property (s_q.seq == sstc_pkg::SEQ_IDLE && !repeat_mode && !trig_tick
        |=> !o_tsm_active)
        else $error("Sequence started without a trigger.");
    a_cal_short: assert property (s_q.cal == sstc_pkg::CAL_COUNT && cal_req && aux_edge
        && !s_q.ctl_osc[sstc_pkg::NOM_BIT] |=> s_q.cal == sstc_pkg::CAL_IDLE)
        else $error("Calibration window was not one aux period.");
    a_cal_long: assert property (s_q.cal == sstc_pkg::CAL_COUNT && cal_req && aux_edge
        && s_q.ctl_osc[sstc_pkg::NOM_BIT]
        && s_q.cal_win != sstc_pkg::CAL_WIN_SLOW |=> s_q.cal == sstc_pkg::CAL_COUNT)
        else $error("Calibration window ended before four aux periods.");

endmodule : sstc_core

// ===== rtl/sstc_pkg.sv
// Constants and types shared by the sensor scan timing control logic.
package sstc_pkg;

    // -------------------------------------------------------------------
    // Register bus and register map
    // -------------------------------------------------------------------
    localparam int unsigned AW            = 8;
    localparam int unsigned DW            = 16;
    localparam int unsigned NUM_DAC       = 8;
    localparam int unsigned NUM_TSM       = 8;
    localparam int unsigned DAC_W         = 10;
    localparam logic [7:0]  ADDR_CTL_CNT  = 8'h00;
    localparam logic [7:0]  ADDR_CTL_OSC  = 8'h01;
    localparam logic [7:0]  ADDR_SCAN_CNT = 8'h02;
    localparam logic [7:0]  ADDR_DAC_BASE = 8'h08;
    localparam logic [7:0]  ADDR_TSM_BASE = 8'h10;

    // -------------------------------------------------------------------
    // Counter and divider control fields
    // -------------------------------------------------------------------
    localparam int unsigned CLR_RD_BIT    = 15;
    localparam int unsigned CNT2_EN_BIT   = 14;
    localparam int unsigned DN_EN_BIT     = 13;
    localparam int unsigned UP_EN_BIT     = 12;
    localparam int unsigned HI_BR_BIT     = 11;
    localparam int unsigned LO_BR_BIT     = 10;
    localparam int unsigned DIVB_LSB      = 7;
    localparam int unsigned DIVA_LSB      = 4;
    localparam int unsigned AUXDIV_LSB    = 2;
    localparam int unsigned FASTDIV_LSB   = 0;

    // -------------------------------------------------------------------
    // Oscillator and repeat control fields
    // -------------------------------------------------------------------
    localparam int unsigned CYC_CNT_LSB   = 8;
    localparam int unsigned REPEAT_BIT    = 7;
    localparam int unsigned TRIM_LSB      = 3;
    localparam int unsigned NOM_BIT       = 2;
    localparam int unsigned CAL_BIT       = 1;
    localparam int unsigned OSC_EN_BIT    = 0;
    localparam logic [15:0] CTL_OSC_WMASK = 16'h00FF;

    // -------------------------------------------------------------------
    // Timing state entry fields
    // -------------------------------------------------------------------
    localparam int unsigned REP_LSB       = 11;
    localparam int unsigned SLOW_BIT      = 10;
    localparam int unsigned STOP_BIT      = 9;

    // -------------------------------------------------------------------
    // Reset values and timing counts
    // -------------------------------------------------------------------
    localparam logic [15:0] CTL_CNT_RST   = 16'h0000;
    localparam logic [15:0] CTL_OSC_RST   = 16'h0040;
    localparam logic [1:0]  CAL_WIN_FAST  = 2'h0;
    localparam logic [1:0]  CAL_WIN_SLOW  = 2'h3;

    typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} sstc_seq_t;
    typedef enum logic [1:0] {CAL_IDLE, CAL_ARM, CAL_COUNT} sstc_cal_t;

endpackage : sstc_pkg

// ===== testbench/sstc_partner.sv
// Far-side model: auxiliary clock source and internal oscillator clock.
module sstc_partner (
    input  wire logic i_osc_enable,
    input  wire logic i_osc_nominal_select,
    output logic      o_aux_clk,
    output logic      o_osc_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // Both clocks start half a nanosecond late so that no edge meets a core clock edge.
    initial begin
        o_aux_clk = 1'b0;
        #0.5;
        forever #500 o_aux_clk = ~o_aux_clk;
    end
    // The oscillator stands still while disabled, as a stopped clock does.
    initial begin
        o_osc_clk = 1'b0;
        #0.5;
        forever #(i_osc_nominal_select ? 500 : 125) o_osc_clk = i_osc_enable & ~o_osc_clk;
    end
endmodule : sstc_partner

// ===== testbench/testbench.sv
// Self-checking bench for the sensor scan timing control block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_core_clk  = 1'b0;
    logic        i_nrst      = 1'b0;
    logic [7:0]  i_addr      = 8'h00;
    logic [15:0] i_wdata     = 16'h0000;
    logic        i_wr        = 1'b0;
    logic        i_rd        = 1'b0;
    logic        i_proc_step = 1'b0;
    logic [3:0]  pbits       = 4'h0;
    logic        rd_d        = 1'b0;
    logic [15:0] o_rdata;
    logic [1:0]  o_next_branch;
    logic [3:0]  o_osc_trim;
    logic [79:0] o_dac_levels;
    logic        aux_clk, osc_clk, osc_en, osc_nom, hf_osc, seq_end;
    logic        tsm_act;
    logic [2:0]  tsm_idx;
    logic [15:0] tsm_entry;
    logic [15:0] exp_q[$];
    logic [15:0] v;
    int          errors      = 0;
    int          num_checks  = 0;
    int          cycles      = 0;
    int          n;
    integer      seed        = 32'h3e3de56a;

    sstc_core dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_aux_clk(aux_clk), .i_osc_clk(osc_clk), .i_proc_step(i_proc_step),
        .i_count_up_bit(pbits[3]), .i_count_down_bit(pbits[2]), .i_high_branch_bit(pbits[1]),
        .i_low_branch_bit(pbits[0]), .o_next_branch(o_next_branch), .o_osc_enable(osc_en),
        .o_osc_nominal_select(osc_nom), .o_osc_trim(o_osc_trim), .o_hf_from_osc(hf_osc), .o_tsm_active(tsm_act),
        .o_tsm_index(tsm_idx), .o_tsm_entry(tsm_entry), .o_seq_end(seq_end), .o_dac_levels(o_dac_levels));
    sstc_partner far_side (.i_osc_enable(osc_en), .i_osc_nominal_select(osc_nom), .o_aux_clk(aux_clk),
        .o_osc_clk(osc_clk));

    // ---------------------------------------------------------------
    // Bus tasks, comparison and closing report
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] got);
        num_checks++;
        if (got !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_core_clk);
        {i_rd, i_addr} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge i_core_clk);
        i_rd <= 1'b0;
    endtask : rd
    task automatic step(input logic [3:0] b);
        @(posedge i_core_clk);
        {i_proc_step, pbits} <= {1'b1, b};
        @(posedge i_core_clk);
        i_proc_step <= 1'b0;
    endtask : step
    task automatic period(output int p);
        n = 0;
        do @(negedge i_core_clk); while (seq_end !== 1'b1 && ++n < 2000);
        p = 0;
        do begin @(negedge i_core_clk); p++; end while (seq_end !== 1'b1 && p < 2000);
    endtask : period
    task automatic seq_chk(input logic [15:0] c, input int e, input logic act, input logic [15:0] ent);
        wr(sstc_pkg::ADDR_CTL_CNT, c);
        period(n);
        period(n);
        chk("sequence period", 16'(e), 16'(n));
        chk("sequencer active", {15'h0, act}, {15'h0, tsm_act});
        chk("first state", 16'h0000, {13'h0, tsm_idx});
        chk("state entry", ent, tsm_entry);
    endtask : seq_chk
    task automatic end_of_test;
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    always #4 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        rd_d <= i_rd;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            end_of_test;
        end
    end
    always @(negedge i_core_clk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) chk("read data", exp_q.pop_front(), o_rdata);
    end

    initial begin
        repeat (2) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        rd(sstc_pkg::ADDR_CTL_CNT, sstc_pkg::CTL_CNT_RST);
        rd(sstc_pkg::ADDR_CTL_OSC, sstc_pkg::CTL_OSC_RST);
        rd(sstc_pkg::ADDR_TSM_BASE, 16'h0000);
        rd(8'hFF, 16'h0000);
        for (int k = 0; k < sstc_pkg::NUM_DAC; k++) begin
            v = 16'($random(seed));
            wr(sstc_pkg::ADDR_DAC_BASE + 8'(k), v);
            rd(sstc_pkg::ADDR_DAC_BASE + 8'(k), v & 16'h03FF);
            chk("dac level", {6'h00, v[9:0]}, {6'h00, o_dac_levels[10*k +: 10]});
        end
        wr(sstc_pkg::ADDR_CTL_CNT, 16'h1000);
        step(4'b1000);
        step(4'b1000);
        step(4'b0100);
        rd(sstc_pkg::ADDR_SCAN_CNT, 16'h0002);
        rd(sstc_pkg::ADDR_SCAN_CNT, 16'h0002);
        wr(sstc_pkg::ADDR_CTL_CNT, 16'hA000);
        step(4'b1000);
        step(4'b0100);
        rd(sstc_pkg::ADDR_SCAN_CNT, 16'h0001);
        rd(sstc_pkg::ADDR_SCAN_CNT, 16'h0000);
        wr(sstc_pkg::ADDR_CTL_CNT, 16'h4000);
        step(4'b0100);
        rd(sstc_pkg::ADDR_SCAN_CNT, 16'hFF00);
        for (int i = 0; i < 4; i++) begin
            wr(sstc_pkg::ADDR_CTL_CNT, 16'(i) << 10);
            step(4'b0011);
            @(negedge i_core_clk);
            chk("next branch", {14'h0, i[1] & i[0], i[0]}, {14'h0, o_next_branch});
        end
        for (int i = 0; i < 2; i++) begin
            v = 16'($random(seed));
            v[7] = 1'b0;
            v[2:0] = {i[0], 1'b0, i[0]};
            wr(sstc_pkg::ADDR_CTL_OSC, v);
            rd(sstc_pkg::ADDR_CTL_OSC, {8'h00, v[7:0]});
            chk("trim", {12'h000, v[6:3]}, {12'h000, o_osc_trim});
            chk("nominal select", {15'h0, i[0]}, {15'h0, osc_nom});
            chk("fast source", {15'h0, i[0]}, {15'h0, hf_osc});
        end
        wr(sstc_pkg::ADDR_CTL_OSC, 16'h0042);
        repeat (300) @(posedge i_core_clk);
        rd(sstc_pkg::ADDR_CTL_OSC, 16'h0042);
        wr(sstc_pkg::ADDR_CTL_OSC, 16'h0043);
        repeat (300) @(posedge i_core_clk);
        rd(sstc_pkg::ADDR_CTL_OSC, 16'h0443);
        wr(sstc_pkg::ADDR_CTL_OSC, 16'h0045);
        repeat (30) @(posedge i_core_clk);
        wr(sstc_pkg::ADDR_CTL_OSC, 16'h0047);
        repeat (700) @(posedge i_core_clk);
        rd(sstc_pkg::ADDR_CTL_OSC, 16'h0447);
        wr(sstc_pkg::ADDR_TSM_BASE, 16'h1000);
        wr(sstc_pkg::ADDR_TSM_BASE + 8'h01, 16'h0200);
        wr(sstc_pkg::ADDR_CTL_OSC, 16'h00C0);
        for (int d = 0; d < 4; d++) begin
            seq_chk(16'(d), 4 << d, 1'b1, 16'h1000);
        end
        wr(sstc_pkg::ADDR_CTL_OSC, 16'h0040);
        seq_chk(16'h0000, 250, 1'b0, 16'h1000);
        seq_chk(16'h0010, 750, 1'b0, 16'h1000);
        seq_chk(16'h0084, 1500, 1'b0, 16'h1000);
        wr(sstc_pkg::ADDR_TSM_BASE, 16'h0C00);
        wr(sstc_pkg::ADDR_CTL_OSC, 16'h00C0);
        seq_chk(16'h0004, 500, 1'b1, 16'h0C00);
        end_of_test;
    end
endmodule : testbench
